// *** verilog/ps_exec_regs.svh ***
// constants for the paired-single execution block
`ifndef PS_EXEC_REGS_SVH
`define PS_EXEC_REGS_SVH

// ****************
// instruction fields
// ****************
`define OPC_PRIMARY 6'h04
`define XO_ABS 10'h108
`define XO_ADD 5'h15
`define XO_CMP_ORD_FIRST 10'h020
`define XO_CMP_ORD_SECOND 10'h060
`define XO_CMP_UNORD_FIRST 10'h000
`define CR_RECORD_FIELD 3'h1

// ****************
// status and control fields
// ****************
`define ST_RESET 32'h00000000
`define ST_EXC_SUM 5'h1F
`define ST_EN_SUM 5'h1E
`define ST_INV_SUM 5'h1D
`define ST_OVF 5'h1C
`define ST_UNF 5'h1B
`define ST_ZDIV 5'h1A
`define ST_INEXACT 5'h19
`define ST_INV_SNAN 5'h18
`define ST_INV_INFSUB 5'h17
`define ST_INV_CMP 5'h13
`define ST_FRAC_RND 5'h12
`define ST_FRAC_INX 5'h11
`define ST_RESFLAG 16:12
`define ST_CCODE 15:12
`define ST_TRAP_INV 5'h07
`define ST_TRAP_OVF 5'h06
`define ST_TRAP_UNF 5'h05
`define ST_TRAP_ZDIV 5'h04
`define ST_TRAP_INX 5'h03
`define ST_RMODE 1:0
`define ST_EXC_MASK 32'h1FF80700
`define ST_INV_MASK 32'h01F80700

// ****************
// single format
// ****************
`define SLOT_W 32
`define ABS_MASK 64'h7FFFFFFF7FFFFFFF
`define SIGN_BIT 32'h80000000
`define QUIET_BIT 32'h00400000
`define QNAN_DEFAULT 32'h7FC00000
`define INF_MAG 31'h7F800000
`define MAX_MAG 31'h7F7FFFFF
`define EXP_MAX 8'hFF
`define EXP_OVF 10'h0FF
`define EXP_ONE 10'h001
`define MANT_W 27
`define ALIGN_LIMIT 10'h01B

// ****************
// rounding modes, compare codes, result classes
// ****************
`define RM_NEAR 2'h0
`define RM_PINF 2'h2
`define RM_NINF 2'h3
`define CC_LT 4'h8
`define CC_GT 4'h4
`define CC_EQ 4'h2
`define CC_UN 4'h1
`define CLS_QNAN 5'h11
`define CLS_NINF 5'h09
`define CLS_NNORM 5'h08
`define CLS_NDEN 5'h18
`define CLS_NZERO 5'h12
`define CLS_PZERO 5'h02
`define CLS_PDEN 5'h14
`define CLS_PNORM 5'h04
`define CLS_PINF 5'h05

`endif

// *** verilog/ps_exec_pkg.sv ***
// types shared by the paired-single execution block
package ps_exec_pkg;

  typedef struct packed
  {
    logic [31:0] value;
    logic fracRounded;
    logic fracInexact;
    logic overflow;
    logic underflow;
  } round_result_type;

endpackage

// *** verilog/add_lane_if.sv ***
// one add lane: operands in, aligned unrounded sum out
`timescale 1ns/1ps
interface add_lane_if;
  logic [31:0] opA;
  logic [31:0] opB;
  logic [1:0] roundMode;
  logic isSpecial;
  logic [31:0] specialVal;
  logic zero;
  logic sign;
  logic [9:0] exponent;
  logic [26:0] mant;
  logic snanHit;
  logic infSubHit;

  modport lane (input opA, opB, roundMode,
    output isSpecial, specialVal, zero, sign, exponent, mant, snanHit, infSubHit);
  modport user (output opA, opB, roundMode,
    input isSpecial, specialVal, zero, sign, exponent, mant, snanHit, infSubHit);
endinterface

// *** verilog/fp_lane_adder.sv ***
// single-precision align, add and normalize for one slot
`timescale 1ns/1ps
`include "ps_exec_regs.svh"
module fp_lane_adder
  import ps_exec_pkg::*;
(
  add_lane_if.lane lane // one slot's operands and sum
);
  logic [7:0] expA, expB;
  logic nanA, nanB, infA, infB, swap, sameSign, signBig;
  logic [9:0] effA, effB, expBig, expSmall, shiftAmt, normExp;
  logic [26:0] extA, extB, bigMant, smallMant, alignedSmall, normMant;
  logic [27:0] rawSum;

  assign expA = lane.opA[30:23];
  assign expB = lane.opB[30:23];
  assign nanA = expA == `EXP_MAX && lane.opA[22:0] != 23'h0;
  assign nanB = expB == `EXP_MAX && lane.opB[22:0] != 23'h0;
  assign infA = expA == `EXP_MAX && lane.opA[22:0] == 23'h0;
  assign infB = expB == `EXP_MAX && lane.opB[22:0] == 23'h0;
  // denormals take exponent one with no hidden bit
  assign effA = expA == 8'h00 ? `EXP_ONE : {2'h0, expA};
  assign effB = expB == 8'h00 ? `EXP_ONE : {2'h0, expB};
  // 24-bit significand and three guard bits; the carry bit is added in the sum
  assign extA = {expA != 8'h00, lane.opA[22:0], 3'h0};
  assign extB = {expB != 8'h00, lane.opB[22:0], 3'h0};
  assign swap = {effB, extB} > {effA, extA};
  assign expBig = swap ? effB : effA;
  assign expSmall = swap ? effA : effB;
  assign bigMant = swap ? extB : extA;
  assign smallMant = swap ? extA : extB;
  assign signBig = swap ? lane.opB[31] : lane.opA[31];
  assign sameSign = lane.opA[31] == lane.opB[31];
  assign shiftAmt = expBig - expSmall;

  // bits shifted out fold into the sticky bit
  always_comb
  begin
    if (shiftAmt >= `ALIGN_LIMIT)
      alignedSmall = {26'h0, |smallMant};
    else
      alignedSmall = (smallMant >> shiftAmt)
        | {26'h0, |(smallMant & ~({`MANT_W{1'b1}} << shiftAmt))};
  end

  assign rawSum = sameSign ? {1'b0, bigMant} + {1'b0, alignedSmall}
    : {1'b0, bigMant} - {1'b0, alignedSmall};

  always_comb
  begin
    normMant = rawSum[26:0];
    normExp = expBig;
    if (rawSum[27])
    begin
      normMant = {rawSum[27:2], rawSum[1] | rawSum[0]};
      normExp = expBig + `EXP_ONE;
    end
    else
    begin
      // stop at exponent one so tiny results stay denormal
      for (int i = 0; i < `MANT_W; i++)
      begin
        if (!normMant[26] && normExp > `EXP_ONE)
        begin
          normMant = normMant << 1;
          normExp = normExp - `EXP_ONE;
        end
      end
    end
  end

  assign lane.snanHit = (nanA & ~lane.opA[22]) | (nanB & ~lane.opB[22]);
  assign lane.infSubHit = infA & infB & ~sameSign;
  assign lane.isSpecial = nanA | nanB | infA | infB;
  assign lane.specialVal = nanA ? (lane.opA | `QUIET_BIT) : nanB ? (lane.opB | `QUIET_BIT)
    : lane.infSubHit ? `QNAN_DEFAULT : infA ? lane.opA : lane.opB;
  assign lane.zero = rawSum == 28'h0;
  assign lane.sign = lane.zero ? (sameSign ? lane.opA[31] : lane.roundMode == `RM_NINF) : signBig;
  assign lane.exponent = normExp;
  assign lane.mant = normMant;
endmodule

// *** verilog/ps_exec_unit.sv ***
// paired-single absolute value, add and compare execution unit
//
// What this block does
// - feature disabled raises illegal instruction instead
// - absolute value decodes as opcode 4, 264
// - absolute value clears each slot's sign bit
// - absolute value ignores NaN, leaves status untouched
// - paired add decodes as opcode 4, 21
// - each slot adds its own pair independently
// - align smaller exponent, then add or subtract
// - keep 24-bit significand plus three guard bits
// - carry out shifts right, bumps exponent
// - normalize when leading bit is zero
// - round each sum by the rounding mode
// - result class from slot 0 unless trapped invalid
// - add updates rounding, range and invalid flags
// - record bit copies summaries into field 1
// - compares decode as opcode 4, 32/96/0
// - compare uses chosen slot, flags from it
// - codes: less, greater, equal, unordered
// - code goes to chosen field and condition code
// - signaling NaN compare sets invalid NaN flag
// - ordered signaling compare, untrapped, sets compare flag
// - ordered quiet NaN sets compare flag, unordered never
`timescale 1ns/1ps
`include "ps_exec_regs.svh"
module ps_exec_unit
  import ps_exec_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic issueValid, // instruction offered this cycle
  input wire logic [31:0] instrWord, // instruction word
  input wire logic [63:0] srcA, // source_reg_a, first slot high
  input wire logic [63:0] srcB, // source_reg_b, first slot high
  input wire logic pairedSingleEnable, // enable bit of impl_config_reg_two
  input wire logic statusWrite, // load status register
  input wire logic [31:0] statusWriteData, // value to load
  output logic doneValid, // an instruction completed
  output logic illegalInstr, // illegal instruction exception
  output logic destWrite, // write dest_reg
  output logic [4:0] destIndex, // dest_reg number
  output logic [63:0] destData, // dest_reg value
  output logic crWrite, // write a condition register field
  output logic [2:0] crIndex, // field number
  output logic [3:0] crData, // field value
  output logic [31:0] fpStatus // fp_status_control contents
);

  // ****************
  // helpers
  // ****************
  function automatic logic isNan(input logic [31:0] v);
    isNan = v[30:23] == `EXP_MAX && v[22:0] != 23'h0;
  endfunction

  function automatic logic isSnan(input logic [31:0] v);
    isSnan = isNan(v) && !v[22];
  endfunction

  // sign-magnitude turned into an unsigned key that orders like the value
  function automatic logic [3:0] cmpCode(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] keyA;
    logic [31:0] keyB;

    keyA = a[31] ? ~a : (a | `SIGN_BIT);
    keyB = b[31] ? ~b : (b | `SIGN_BIT);
    if (isNan(a) || isNan(b))
      cmpCode = `CC_UN;
    else if ((a[30:0] | b[30:0]) == 31'h0)
      cmpCode = `CC_EQ;
    else if (keyA < keyB)
      cmpCode = `CC_LT;
    else if (keyA > keyB)
      cmpCode = `CC_GT;
    else
      cmpCode = `CC_EQ;
  endfunction

  function automatic logic [4:0] resultClass(input logic [31:0] v);
    logic expAll;
    logic expNone;
    logic fracNone;

    expAll = v[30:23] == `EXP_MAX;
    expNone = v[30:23] == 8'h00;
    fracNone = v[22:0] == 23'h0;
    if (expAll && !fracNone)
      resultClass = `CLS_QNAN;
    else if (expAll)
      resultClass = v[31] ? `CLS_NINF : `CLS_PINF;
    else if (expNone && fracNone)
      resultClass = v[31] ? `CLS_NZERO : `CLS_PZERO;
    else if (expNone)
      resultClass = v[31] ? `CLS_NDEN : `CLS_PDEN;
    else
      resultClass = v[31] ? `CLS_NNORM : `CLS_PNORM;
  endfunction

  // mant holds the hidden bit at 26 and guard, round, sticky at 2..0
  function automatic round_result_type roundSingle(input logic sign, input logic [9:0] expIn,
    input logic [26:0] mant, input logic [1:0] mode);
    round_result_type res;
    logic inexact;
    logic up;
    logic toInf;
    logic [24:0] sig;
    logic [9:0] expR;

    res = '0;
    inexact = |mant[2:0];
    case (mode)
      `RM_NEAR: up = mant[2] & (mant[1] | mant[0] | mant[3]);
      `RM_PINF: up = ~sign & inexact;
      `RM_NINF: up = sign & inexact;
      default: up = 1'b0;
    endcase
    sig = {1'b0, mant[26:3]} + {24'h000000, up};
    expR = expIn;
    if (sig[24])
    begin
      sig = sig >> 1;
      expR = expIn + `EXP_ONE;
    end

    res.fracRounded = up;
    res.fracInexact = inexact;
    // tininess judged before rounding
    res.underflow = ~mant[26] & inexact;
    toInf = mode == `RM_NEAR || (mode == `RM_PINF && !sign) || (mode == `RM_NINF && sign);
    if (expR >= `EXP_OVF)
    begin
      res.overflow = 1'b1;
      res.fracInexact = 1'b1;
      res.value = {sign, toInf ? `INF_MAG : `MAX_MAG};
    end
    else
      res.value = {sign, sig[23] ? expR[7:0] : 8'h00, sig[22:0]};
    return res;
  endfunction

  // ****************
  // decode
  // ****************
  wire logic primaryHit = instrWord[31:26] == `OPC_PRIMARY;
  wire logic recordBit = instrWord[0];
  wire logic [9:0] extLong = instrWord[10:1];
  wire logic [4:0] extShort = instrWord[5:1];
  wire logic [2:0] crDestField = instrWord[25:23];
  wire logic isAbs = primaryHit && extLong == `XO_ABS && instrWord[20:16] == 5'h00;
  wire logic isAdd = primaryHit && extShort == `XO_ADD && instrWord[10:6] == 5'h00;
  wire logic cmpForm = primaryHit && instrWord[22:21] == 2'h0 && !recordBit;
  wire logic isCmpOrdFirst = cmpForm && extLong == `XO_CMP_ORD_FIRST;
  wire logic isCmpOrdSecond = cmpForm && extLong == `XO_CMP_ORD_SECOND;
  wire logic isCmpUnordFirst = cmpForm && extLong == `XO_CMP_UNORD_FIRST;
  wire logic isCmp = isCmpOrdFirst || isCmpOrdSecond || isCmpUnordFirst;
  wire logic knownOp = isAbs || isAdd || isCmp;

  // ****************
  // dispatch
  // ****************
  // words outside this subset are left for other units
  wire logic takeOp = issueValid && knownOp;
  wire logic raiseIllegal = takeOp && !pairedSingleEnable;
  wire logic execOp = takeOp && pairedSingleEnable;
  wire logic execAbs = execOp && isAbs;
  wire logic execAdd = execOp && isAdd;
  wire logic execCmp = execOp && isCmp;

  logic [31:0] status_reg;
  logic [31:0] status_next;
  wire logic [1:0] roundMode = status_reg[`ST_RMODE];
  wire logic trapInv = status_reg[`ST_TRAP_INV];

  // ****************
  // add lanes
  // ****************
  logic [31:0] sumSlot [2];
  logic [1:0] laneRnd, laneInx, laneOvf, laneUnf, laneSnan, laneInfSub;

  for (genvar s = 0; s < 2; s++)
  begin : g_lane
    add_lane_if laneIf();
    round_result_type rounded;
    wire logic plain = !laneIf.isSpecial && !laneIf.zero;

    // slot 0 sits in the upper word of each register
    assign laneIf.opA = srcA[`SLOT_W * (1 - s) +: `SLOT_W];
    assign laneIf.opB = srcB[`SLOT_W * (1 - s) +: `SLOT_W];
    assign laneIf.roundMode = roundMode;
    fp_lane_adder u_fp_lane_adder (
      .lane(laneIf.lane)
    );
    assign rounded = roundSingle(laneIf.sign, laneIf.exponent, laneIf.mant, roundMode);
    assign sumSlot[s] = laneIf.isSpecial ? laneIf.specialVal
      : laneIf.zero ? {laneIf.sign, 31'h0} : rounded.value;

    assign laneRnd[s] = plain && rounded.fracRounded;
    assign laneInx[s] = plain && rounded.fracInexact;
    assign laneOvf[s] = plain && rounded.overflow;
    assign laneUnf[s] = plain && rounded.underflow;
    assign laneSnan[s] = laneIf.snanHit;
    assign laneInfSub[s] = laneIf.infSubHit;
  end

  wire logic addInvalid = |laneSnan || |laneInfSub;

  // ****************
  // compare
  // ****************
  wire logic [31:0] cmpA = isCmpOrdSecond ? srcA[31:0] : srcA[63:32];
  wire logic [31:0] cmpB = isCmpOrdSecond ? srcB[31:0] : srcB[63:32];
  wire logic [3:0] cmpResult = cmpCode(cmpA, cmpB);
  wire logic cmpSnan = isSnan(cmpA) || isSnan(cmpB);
  wire logic cmpQnan = isNan(cmpA) || isNan(cmpB);
  wire logic cmpOrdered = isCmpOrdFirst || isCmpOrdSecond;
  // unordered compares never reach the compare flag
  wire logic cmpSetsInvCmp = cmpOrdered && (cmpSnan ? !trapInv : cmpQnan);

  // ****************
  // status update
  // ****************
  // a software load and an instruction in one cycle: the flags the
  // instruction raises are laid on top of the loaded value
  wire logic [31:0] statusBase = statusWrite ? statusWriteData : status_reg;
  logic [31:0] newExc;

  always_comb
  begin
    status_next = statusBase;
    if (execAdd)
    begin
      status_next[`ST_FRAC_RND] = |laneRnd;
      status_next[`ST_FRAC_INX] = |laneInx;
      if (|laneOvf)
        status_next[`ST_OVF] = 1'b1;
      if (|laneUnf)
        status_next[`ST_UNF] = 1'b1;
      if (|laneInx)
        status_next[`ST_INEXACT] = 1'b1;
      if (|laneSnan)
        status_next[`ST_INV_SNAN] = 1'b1;
      if (|laneInfSub)
        status_next[`ST_INV_INFSUB] = 1'b1;
      if (!(addInvalid && trapInv))
        status_next[`ST_RESFLAG] = resultClass(sumSlot[0]);
    end

    if (execCmp)
    begin
      status_next[`ST_CCODE] = cmpResult;
      if (cmpSnan)
        status_next[`ST_INV_SNAN] = 1'b1;
      if (cmpSetsInvCmp)
        status_next[`ST_INV_CMP] = 1'b1;
    end

    newExc = status_next & ~statusBase & `ST_EXC_MASK;
    if (|newExc)
      status_next[`ST_EXC_SUM] = 1'b1;
    status_next[`ST_INV_SUM] = |(status_next & `ST_INV_MASK);
    status_next[`ST_EN_SUM] = (status_next[`ST_INV_SUM] & status_next[`ST_TRAP_INV])
      | (status_next[`ST_OVF] & status_next[`ST_TRAP_OVF])
      | (status_next[`ST_UNF] & status_next[`ST_TRAP_UNF])
      | (status_next[`ST_ZDIV] & status_next[`ST_TRAP_ZDIV])
      | (status_next[`ST_INEXACT] & status_next[`ST_TRAP_INX]);
  end

  // ****************
  // results
  // ****************
  // absolute value never touches status, so its record copy sees
  // the status unchanged
  wire logic [63:0] absData = srcB & `ABS_MASK;
  wire logic [63:0] addData = {sumSlot[0], sumSlot[1]};
  wire logic recordUpdate = (execAbs || execAdd) && recordBit;
  wire logic [3:0] recordData = {status_next[`ST_EXC_SUM], status_next[`ST_EN_SUM],
    status_next[`ST_INV_SUM], status_next[`ST_OVF]};

  logic doneValid_reg;
  logic illegal_reg;
  logic destWrite_reg;
  logic crWrite_reg;
  logic [4:0] destIndex_reg;
  logic [63:0] destData_reg;
  logic [2:0] crIndex_reg;
  logic [3:0] crData_reg;

  wire logic [63:0] destData_next = execAbs ? absData : addData;
  wire logic [2:0] crIndex_next = execCmp ? crDestField : `CR_RECORD_FIELD;
  wire logic [3:0] crData_next = execCmp ? cmpResult : recordData;

  // ****************
  // registers
  // ****************
  // results hold until rewritten
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_reg <= `ST_RESET;
      doneValid_reg <= 1'b0;
      illegal_reg <= 1'b0;
      destWrite_reg <= 1'b0;
      crWrite_reg <= 1'b0;
      destIndex_reg <= 5'h00;
      destData_reg <= 64'h0000000000000000;
      crIndex_reg <= 3'h0;
      crData_reg <= 4'h0;
    end
    else
    begin
      status_reg <= status_next;
      doneValid_reg <= execOp;
      illegal_reg <= raiseIllegal;
      destWrite_reg <= execAbs || execAdd;
      crWrite_reg <= execCmp || recordUpdate;
      if (execAbs || execAdd)
      begin
        destIndex_reg <= instrWord[25:21];
        destData_reg <= destData_next;
      end
      if (execCmp || recordUpdate)
      begin
        crIndex_reg <= crIndex_next;
        crData_reg <= crData_next;
      end
    end
  end

  // ****************
  // outputs
  // ****************
  assign doneValid = doneValid_reg;
  assign illegalInstr = illegal_reg;
  assign destWrite = destWrite_reg;
  assign destIndex = destIndex_reg;
  assign destData = destData_reg;
  assign crWrite = crWrite_reg;
  assign crIndex = crIndex_reg;
  assign crData = crData_reg;
  assign fpStatus = status_reg;

endmodule

// *** dv/ps_exec_unit_props.sv ***
// concurrent checks on the ports of the paired-single execution unit
`timescale 1ns/1ps
module ps_exec_unit_props
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic issueValid, // offer
  input wire logic [31:0] instrWord, // word
  input wire logic [63:0] srcB, // operand b
  input wire logic pairedSingleEnable, // feature on
  input wire logic statusWrite, // status load
  input wire logic doneValid, // done pulse
  input wire logic illegalInstr, // illegal pulse
  input wire logic destWrite, // result pulse
  input wire logic [4:0] destIndex, // result reg
  input wire logic [63:0] destData, // result
  input wire logic crWrite, // cr pulse
  input wire logic [2:0] crIndex, // cr field
  input wire logic [3:0] crData, // cr value
  input wire logic [31:0] fpStatus // status
);
  // ****************
  // decode as seen from the ports
  // ****************
  wire opc4 = instrWord[31:26] == 6'h04;
  wire isAbs = opc4 && instrWord[10:1] == 10'h108 && instrWord[20:16] == 5'h00;
  wire isAdd = opc4 && instrWord[5:1] == 5'h15 && instrWord[10:6] == 5'h00;
  wire isCmp = opc4 && instrWord[22:21] == 2'h0 && !instrWord[0]
    && (instrWord[10:1] == 10'h020 || instrWord[10:1] == 10'h060 || instrWord[10:1] == 10'h000);
  wire known = issueValid && (isAbs || isAdd || isCmp);
  wire go = known && pairedSingleEnable;
  wire [4:0] destFld = instrWord[25:21];
  wire [2:0] crFld = instrWord[25:23];
  wire recBit = instrWord[0];
  wire invCmpBit = fpStatus[19];
  wire invSnanBit = fpStatus[24];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************
  // properties
  // ****************
  property p_illegal;
    known && !pairedSingleEnable |=> illegalInstr && !doneValid && !destWrite && !crWrite;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal form executed");
  property p_done_cause;
    doneValid |-> $past(go) && !illegalInstr;
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without cause");
  property p_malformed;
    issueValid && opc4 && !(isAbs || isAdd || isCmp) |=> !doneValid && !illegalInstr;
  endproperty
  a_malformed: assert property (p_malformed) else $error("malformed word answered");
  property p_abs_data;
    go && isAbs |=> destWrite && destIndex == $past(destFld) && destData == ($past(srcB) & 64'h7FFFFFFF7FFFFFFF);
  endproperty
  a_abs_data: assert property (p_abs_data) else $error("abs result wrong");
  property p_abs_status;
    go && isAbs && !statusWrite |=> $stable(fpStatus);
  endproperty
  a_abs_status: assert property (p_abs_status) else $error("abs touched status");
  property p_record;
    go && (isAbs || isAdd) && !statusWrite |=> crWrite == $past(recBit)
      && (!crWrite || (crIndex == 3'h1 && crData == fpStatus[31:28]));
  endproperty
  a_record: assert property (p_record) else $error("record field wrong");
  property p_cmp_cr;
    go && isCmp |=> crWrite && !destWrite && crIndex == $past(crFld) && crData == fpStatus[15:12] && $onehot(crData);
  endproperty
  a_cmp_cr: assert property (p_cmp_cr) else $error("compare code wrong");
  property p_unord_vc;
    go && isCmp && instrWord[10:1] == 10'h000 && !statusWrite |=> $stable(invCmpBit);
  endproperty
  a_unord_vc: assert property (p_unord_vc) else $error("unordered set compare flag");
  property p_sticky;
    $rose(invSnanBit) && !$past(statusWrite) |-> fpStatus[31];
  endproperty
  a_sticky: assert property (p_sticky) else $error("summary not set");
endmodule

// *** dv/ps_dispatch_model.sv ***
// dispatch and register file model feeding the execution unit
`timescale 1ns/1ps
module ps_dispatch_model
(
  input wire logic clk, // core clock
  input wire logic reqValid, // bench asks to issue
  input wire logic [31:0] reqWord, // word to issue
  input wire logic destWrite, // result write
  input wire logic [4:0] destIndex, // result reg
  input wire logic [63:0] destData, // result
  output logic issueValid, // to unit
  output logic [31:0] instrWord, // to unit
  output logic [63:0] srcA, // operand a
  output logic [63:0] srcB // operand b
);
  logic [63:0] fpr [32];

  // off-cycle operands show the inverse so stale values cannot pass
  assign issueValid = reqValid;
  assign instrWord = reqWord;
  assign srcA = reqValid ? fpr[reqWord[20:16]] : ~fpr[reqWord[20:16]];
  assign srcB = reqValid ? fpr[reqWord[15:11]] : ~fpr[reqWord[15:11]];

  always @(posedge clk)
  begin
    if (destWrite)
      fpr[destIndex] <= destData;
  end
endmodule

// *** dv/paired_single_abs_add_compare_test.sv ***
// self-checking bench for the paired-single execution unit
`timescale 1ns/1ps
module paired_single_abs_add_compare_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic [31:0] reqWord = 32'h00000000;
  logic pairedSingleEnable = 1'b1;
  logic statusWrite = 1'b0;
  logic [31:0] statusWriteData = 32'h00000000;
  logic issueValid, doneValid, illegalInstr, destWrite, crWrite;
  logic [31:0] instrWord, fpStatus, outs;
  logic [63:0] srcA, srcB, destData;
  logic [4:0] destIndex;
  logic [2:0] crIndex;
  logic [3:0] crData;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  always #4 clk = ~clk;
  assign outs = {12'h000, doneValid, illegalInstr, destWrite, crWrite, 1'h0, crIndex, crData, 3'h0, destIndex};

  ps_exec_unit u_ps_exec_unit (.clk(clk), .rst(rst), .issueValid(issueValid), .instrWord(instrWord),
    .srcA(srcA), .srcB(srcB), .pairedSingleEnable(pairedSingleEnable), .statusWrite(statusWrite),
    .statusWriteData(statusWriteData), .doneValid(doneValid), .illegalInstr(illegalInstr),
    .destWrite(destWrite), .destIndex(destIndex), .destData(destData), .crWrite(crWrite),
    .crIndex(crIndex), .crData(crData), .fpStatus(fpStatus));
  ps_dispatch_model u_ps_dispatch_model (.clk(clk), .reqValid(reqValid), .reqWord(reqWord),
    .destWrite(destWrite), .destIndex(destIndex), .destData(destData), .issueValid(issueValid),
    .instrWord(instrWord), .srcA(srcA), .srcB(srcB));

  // ****************
  // access tasks
  // ****************
  function automatic logic [31:0] mk(input logic [4:0] d, a, b, input logic [9:0] x, input logic rc);
    return {6'h04, d, a, b, x, rc};
  endfunction

  task automatic cmp64(input string what, input logic [63:0] expv, input logic [63:0] got);
    checks++;
    if (got !== expv)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic cmp32(input string what, input logic [31:0] expv, input logic [31:0] got);
    cmp64(what, {32'h0, expv}, {32'h0, got});
  endtask

  // answer lands on the same edge that takes the word; sample just after that edge
  task automatic issue(input logic [31:0] w);
    @(posedge clk);
    reqValid <= 1'b1;
    reqWord <= w;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
  endtask

  task automatic set_status(input logic [31:0] v);
    @(posedge clk);
    statusWrite <= 1'b1;
    statusWriteData <= v;
    @(posedge clk);
    statusWrite <= 1'b0;
  endtask

  task automatic run_cmp(input logic [9:0] x, input logic [4:0] a, b, input logic [2:0] f,
    input logic [31:0] st, input logic [3:0] code, input logic [31:0] stat);
    set_status(st);
    issue(mk({f, 2'h0}, a, b, x, 1'b0));
    cmp32("compare outs", {12'h000, 4'h9, 1'h0, f, code, 8'h0E}, outs);
    cmp32("compare status", stat, fpStatus);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // ****************
  // scenarios
  // ****************
  initial
  begin
    for (int i = 0; i < 32; i++)
      u_ps_dispatch_model.fpr[i] = 64'h0;
    u_ps_dispatch_model.fpr[1] = 64'h3F800000_3FC00000;
    u_ps_dispatch_model.fpr[2] = 64'h40000000_3FC00000;
    u_ps_dispatch_model.fpr[3] = 64'hFFC00001_80000005;
    u_ps_dispatch_model.fpr[4] = 64'h7F800000_40400000;
    u_ps_dispatch_model.fpr[5] = 64'hFF800000_BF800000;
    u_ps_dispatch_model.fpr[6] = 64'h3F800000_00000000;
    u_ps_dispatch_model.fpr[7] = 64'h33800000_00000000;
    u_ps_dispatch_model.fpr[8] = 64'h7F800001_7FC00000;
    u_ps_dispatch_model.fpr[9] = 64'h80000000_40A00000;
    u_ps_dispatch_model.fpr[10] = 64'h00000000_40400000;
    u_ps_dispatch_model.fpr[15] = 64'h7F7FFFFF_00000000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    issue(mk(5'h0B, 5'h00, 5'h03, 10'h108, 1'b1));
    cmp64("abs data", 64'h7FC00001_00000005, destData);
    cmp32("abs outs", 32'h000B100B, outs);
    cmp32("abs status", 32'h00000000, fpStatus);
    issue(mk(5'h0C, 5'h01, 5'h02, 10'h015, 1'b0));
    cmp64("add data", 64'h40400000_40400000, destData);
    cmp32("add outs", 32'h000A100C, outs);
    cmp32("add status", 32'h00004000, fpStatus);
    issue(mk(5'h0D, 5'h04, 5'h05, 10'h015, 1'b1));
    cmp64("inf sub data", 64'h7FC00000_40000000, destData);
    cmp32("inf sub outs", 32'h000B1A0D, outs);
    cmp32("inf sub status", 32'hA0811000, fpStatus);
    // a half-ulp tie needs the guard bits; only round toward plus infinity lifts it to the next value
    for (int m = 0; m < 4; m++)
    begin
      set_status(32'(m));
      issue(mk(5'h0E, 5'h06, 5'h07, 10'h015, 1'b0));
      cmp64("round data", {(m == 2) ? 32'h3F800001 : 32'h3F800000, 32'h0}, destData);
      cmp32("round status", 32'h82024000 | 32'(m) | ((m == 2) ? 32'h00040000 : 32'h0), fpStatus);
    end
    run_cmp(10'h020, 5'h06, 5'h02, 3'h2, 32'h0, 4'h8, 32'h00008000);
    run_cmp(10'h060, 5'h09, 5'h0A, 3'h7, 32'h0, 4'h4, 32'h00004000);
    run_cmp(10'h000, 5'h09, 5'h0A, 3'h0, 32'h0, 4'h2, 32'h00002000);
    run_cmp(10'h000, 5'h08, 5'h06, 3'h3, 32'h0, 4'h1, 32'hA1001000);
    run_cmp(10'h060, 5'h08, 5'h06, 3'h4, 32'h0, 4'h1, 32'hA0081000);
    run_cmp(10'h020, 5'h08, 5'h06, 3'h5, 32'h0, 4'h1, 32'hA1081000);
    run_cmp(10'h020, 5'h08, 5'h06, 3'h6, 32'h80, 4'h1, 32'hE1001080);
    @(posedge clk);
    pairedSingleEnable <= 1'b0;
    issue(mk(5'h0C, 5'h01, 5'h02, 10'h015, 1'b1));
    cmp32("illegal outs", 32'h0004610E, outs);
    cmp64("illegal data", 64'h3F800000_00000000, destData);
    cmp32("illegal status", 32'hE1001080, fpStatus);
    @(posedge clk);
    pairedSingleEnable <= 1'b1;
    issue(mk(5'h0B, 5'h01, 5'h03, 10'h108, 1'b0));
    cmp32("reserved outs", 32'h0000610E, outs);
    issue(mk(5'h0E, 5'h0F, 5'h0F, 10'h015, 1'b0));
    cmp64("ovf data", 64'h7F800000_00000000, destData);
    cmp32("ovf status", 32'hF3025080, fpStatus);
    stop_test();
  end
endmodule

bind ps_exec_unit ps_exec_unit_props u_ps_exec_unit_props (.clk(clk), .rst(rst), .issueValid(issueValid),
  .instrWord(instrWord), .srcB(srcB), .pairedSingleEnable(pairedSingleEnable), .statusWrite(statusWrite),
  .doneValid(doneValid), .illegalInstr(illegalInstr), .destWrite(destWrite), .destIndex(destIndex),
  .destData(destData), .crWrite(crWrite), .crIndex(crIndex), .crData(crData), .fpStatus(fpStatus));
